// file: shared/sas_defines.vh
// constants for the cable-side host adapter: offsets, fields, timing counts
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH
// byte offsets within the adapter's processor window
`define SAS_OFF_DATA0 4'h8
`define SAS_OFF_ARM 4'hc
`define SAS_OFF_SELECT 4'hd
`define SAS_OFF_STATUS 4'hd
// status register fields
`define SAS_ST_BUSY 7
`define SAS_ST_CMD 3
`define SAS_ST_WR 2
`define SAS_ST_RD 1
`define SAS_ST_STAT 0
`define SAS_STATUS_RST 8'h00
// clock period in ps (250 MHz)
`define SAS_CLK_PS 4000
// handshake times in ps, fastest documented processor clock figures
`define SAS_T_ACK_WR_PS 40000
`define SAS_T_ACK_RD_PS 75000
`define SAS_T_REL_WR_PS 95000
`define SAS_T_REL_RD_PS 45000
// least times round up, longest rounds down
`define SAS_ACK_WR_CYC ((`SAS_T_ACK_WR_PS + `SAS_CLK_PS - 1) / `SAS_CLK_PS)
`define SAS_ACK_RD_CYC ((`SAS_T_ACK_RD_PS + `SAS_CLK_PS - 1) / `SAS_CLK_PS)
`define SAS_REL_WR_CYC ((`SAS_T_REL_WR_PS + `SAS_CLK_PS - 1) / `SAS_CLK_PS)
`define SAS_REL_RD_CYC (`SAS_T_REL_RD_PS / `SAS_CLK_PS)
// select / transfer time-out in ns (later boards)
`define SAS_T_TMO_NS 125000
`define SAS_TMO_CYC (`SAS_T_TMO_NS / 4)
`endif

// file: hdl/sas_host_port.v
// cable-side host adapter: status, interrupt arming, paced byte transfers
// Notes on behaviour
// - ack drops after req falls: at least 95 ns write, within 45 ns read
// - armed adapter raises level-1 interrupt on data or status requests
// - command requests never raise the interrupt
// - any write to the arming location arms; data ignored
// - request already pending when armed interrupts at once
// - vector fetch disarms; no more interrupts until re-armed
// - request withdrawn before service drops interrupt but stays armed
// - at most one acknowledged interrupt per arming write; no software clear
// - sole level-1 source; no source identification status
// - status bit 7 busy from selection until the sequence ends
// - phase lines decode to write, read, status and command bits
// - data port access moves 1, 2 or 4 bytes paced by req
// - byte write to select register starts selection of that controller
// - no busy within time-out after select ends access with bus error
// - data port access against the io direction ends with bus error
// - cable reset follows the board reset, no other control
`timescale 1ns/1ps
`include "sas_defines.vh"
module sas_host_port #(
    parameter TMO_CYC = `SAS_TMO_CYC
) (
    // clock and board reset
    input wire CLK,
    input wire RST_N,
    // processor access: strobe held until DONE or BERR
    input wire CPU_REQ,
    input wire CPU_WR,
    input wire [3:0] CPU_ADDR,
    input wire [1:0] CPU_SIZE,
    input wire [31:0] CPU_WDATA,
    output reg [31:0] CPU_RDATA,
    output reg CPU_DONE,
    output reg CPU_BERR,
    // interrupt request and vector-fetch acknowledge
    output reg IRQ1,
    input wire IACK,
    // cable inputs, active low except the data bus DB_IN, which is taken as it stands
    input wire REQ_N,
    input wire IO_N,
    input wire CD_N,
    input wire MSG_N,
    input wire BSY_N,
    input wire [7:0] DB_IN,
    // cable outputs, active low except DB_OUT, which carries the byte as it stands; data output enable low while driving
    output reg ACK_N,
    output reg SEL_N,
    output reg RST_OUT_N,
    output reg [7:0] DB_OUT,
    output reg DB_OE_N
);
    localparam S_IDLE = 3'h0;
    localparam S_SEL = 3'h1;
    localparam S_WAITREQ = 3'h2;
    localparam S_ACKDLY = 3'h3;
    localparam S_ACKON = 3'h4;
    localparam S_RELDLY = 3'h5;
    localparam S_END = 3'h6;

    // two-stage synchronisers for all cable inputs
    reg [12:0] sy1_ff;
    reg [12:0] sy2_ff;
    always @(posedge CLK) begin
        sy1_ff <= {REQ_N, IO_N, CD_N, MSG_N, BSY_N, DB_IN};
        sy2_ff <= sy1_ff;
    end
    wire req = ~sy2_ff[12];
    wire io_in = ~sy2_ff[11]; // high: controller to host
    wire cd = ~sy2_ff[10];
    wire busy_in = ~sy2_ff[8];
    wire [7:0] db = sy2_ff[7:0];

    wire ph_wr = req & ~cd & ~io_in;
    wire ph_rd = req & ~cd & io_in;
    wire ph_st = req & cd & io_in;
    wire ph_cmd = req & cd & ~io_in;

    reg [2:0] st_ff;
    reg [15:0] cnt_ff;
    reg [31:0] tmo_ff;
    reg [1:0] left_ff;
    reg rd_ff;
    reg armed_ff;
    reg [31:0] shift_ff;
    reg [1:0] bidx_ff;

    // number of bytes minus one for the access size
    wire [1:0] nbytes = (CPU_SIZE == 2'h0) ? 2'h0 : (CPU_SIZE == 2'h1) ? 2'h1 : 2'h3;
    wire acc_data = CPU_ADDR[3:2] == 2'h2;
    wire acc_arm = CPU_ADDR == `SAS_OFF_ARM;
    wire acc_sel = CPU_ADDR == `SAS_OFF_SELECT;
    wire irq_cond = ph_wr | ph_rd | ph_st;

    // access sequencer and cable handshake
    always @(posedge CLK) begin
        if (!RST_N) begin
            st_ff <= S_IDLE;
            cnt_ff <= 16'h0000;
            tmo_ff <= 32'h00000000;
            left_ff <= 2'h0;
            rd_ff <= 1'b0;
            shift_ff <= 32'h00000000;
            bidx_ff <= 2'h0;
            CPU_RDATA <= 32'h00000000;
            CPU_DONE <= 1'b0;
            CPU_BERR <= 1'b0;
            ACK_N <= 1'b1;
            SEL_N <= 1'b1;
            DB_OUT <= 8'h00;
            DB_OE_N <= 1'b1;
        end else begin
            CPU_DONE <= 1'b0;
            CPU_BERR <= 1'b0;
            case (st_ff)
                S_IDLE: begin
                    tmo_ff <= 32'h00000000;
                    if (CPU_REQ) begin
                        if (acc_sel && CPU_WR && CPU_SIZE == 2'h0) begin
                            // put id on bus and assert select in the same cycle
                            DB_OUT <= CPU_WDATA[7:0];
                            DB_OE_N <= 1'b0;
                            SEL_N <= 1'b0;
                            st_ff <= S_SEL;
                        end else if (acc_sel && !CPU_WR) begin
                            CPU_RDATA <= {24'h000000, busy_in, 3'h0, ph_cmd, ph_wr, ph_rd, ph_st};
                            CPU_DONE <= 1'b1;
                            st_ff <= S_END;
                        end else if (acc_arm && CPU_WR) begin
                            CPU_DONE <= 1'b1;
                            st_ff <= S_END;
                        end else if (acc_data) begin
                            rd_ff <= ~CPU_WR;
                            left_ff <= nbytes;
                            bidx_ff <= 2'h0;
                            shift_ff <= CPU_WDATA << (8 * (3 - nbytes));
                            st_ff <= S_WAITREQ;
                        end else begin
                            CPU_BERR <= 1'b1;
                            st_ff <= S_END;
                        end
                    end
                end
                S_SEL: begin
                    tmo_ff <= tmo_ff + 32'h1;
                    if (busy_in) begin
                        SEL_N <= 1'b1;
                        DB_OE_N <= 1'b1;
                        CPU_DONE <= 1'b1;
                        st_ff <= S_END;
                    end else if (tmo_ff >= TMO_CYC - 1) begin
                        SEL_N <= 1'b1;
                        DB_OE_N <= 1'b1;
                        CPU_BERR <= 1'b1;
                        st_ff <= S_END;
                    end
                end
                S_WAITREQ: begin
                    tmo_ff <= tmo_ff + 32'h1;
                    if (req && (io_in != rd_ff || cd)) begin
                        CPU_BERR <= 1'b1;
                        st_ff <= S_END;
                    end else if (req) begin
                        if (!rd_ff) begin
                            DB_OUT <= shift_ff[31:24];
                            DB_OE_N <= 1'b0;
                        end
                        cnt_ff <= 16'h0001;
                        st_ff <= S_ACKDLY;
                    end else if (tmo_ff >= TMO_CYC - 1) begin
                        CPU_BERR <= 1'b1;
                        st_ff <= S_END;
                    end
                end
                S_ACKDLY: begin
                    cnt_ff <= cnt_ff + 16'h1;
                    if (cnt_ff >= (rd_ff ? `SAS_ACK_RD_CYC : `SAS_ACK_WR_CYC)) begin
                        ACK_N <= 1'b0;
                        if (rd_ff)
                            shift_ff <= {shift_ff[23:0], db};
                        st_ff <= S_ACKON;
                    end
                end
                S_ACKON: begin
                    if (!req) begin
                        cnt_ff <= 16'h0001;
                        st_ff <= S_RELDLY;
                        // read release is prompt, bounded by the 45 ns figure
                        if (rd_ff || `SAS_REL_WR_CYC <= 1) begin
                            ACK_N <= 1'b1;
                            st_ff <= S_RELDLY;
                        end
                    end
                end
                S_RELDLY: begin
                    cnt_ff <= cnt_ff + 16'h1;
                    // write holds ack until release delay passes
                    if (rd_ff || cnt_ff >= `SAS_REL_WR_CYC) begin
                        ACK_N <= 1'b1;
                        DB_OE_N <= 1'b1;
                        tmo_ff <= 32'h00000000;
                        shift_ff <= rd_ff ? shift_ff : {shift_ff[23:0], 8'h00};
                        // next byte of the access or finish
                        if (left_ff == 2'h0) begin
                            CPU_RDATA <= shift_ff;
                            CPU_DONE <= 1'b1;
                            st_ff <= S_END;
                        end else begin
                            left_ff <= left_ff - 2'h1;
                            st_ff <= S_WAITREQ;
                        end
                    end
                end
                S_END: begin
                    // wait for processor to drop its strobe
                    if (!CPU_REQ)
                        st_ff <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    // sole level-1 source
    // interrupt arming; no source register since nothing else shares the level
    always @(posedge CLK) begin
        if (!RST_N) begin
            armed_ff <= 1'b0;
            IRQ1 <= 1'b0;
        end else begin
            // vector fetch disarms, set below wins for a same-cycle rewrite
            if (IACK && IRQ1)
                armed_ff <= 1'b0;
            // any write to arming location arms
            if (st_ff == S_IDLE && CPU_REQ && CPU_WR && acc_arm)
                armed_ff <= 1'b1;
            // one acknowledged interrupt per arm since acknowledge clears the arm
            IRQ1 <= armed_ff & irq_cond & ~(IACK & IRQ1);
        end
    end

    always @(posedge CLK) begin
        RST_OUT_N <= RST_N;
    end
endmodule // sas_host_port

// file: bench/sas_host_port_asserts.sv
// port checker for the cable-side host adapter
`timescale 1ns/1ps
module sas_host_port_chk (
    // watched ports
    input wire CLK, input wire RST_N, input wire CPU_REQ, input wire CPU_WR,
    input wire [3:0] CPU_ADDR, input wire CPU_DONE, input wire IRQ1, input wire IACK,
    input wire REQ_N, input wire IO_N, input wire CD_N, input wire BSY_N,
    input wire ACK_N, input wire SEL_N, input wire RST_OUT_N, input wire DB_OE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    reg [3:0] gap_ff;
    reg req_d_ff;
    wire qual = !REQ_N && !(!CD_N && IO_N);
    // arming write on the edge where its strobe is first seen high
    wire arm = CPU_REQ && !req_d_ff && CPU_WR && CPU_ADDR == 4'hc;
    // cycles since a data or status request; saturates so old requests age out
    always @(posedge CLK) begin
        req_d_ff <= CPU_REQ;
        gap_ff <= (!RST_N) ? 4'hf : qual ? 4'h0 : (gap_ff == 4'hf) ? gap_ff : gap_ff + 4'h1;
    end
    AST_CABLE_RST: assert property (disable iff (1'b0) !RST_N |=> !RST_OUT_N)
        else $error("cable reset not driven");
    AST_ACK_LEAST: assert property ($fell(ACK_N) |-> !$past(REQ_N, 8))
        else $error("ack too soon after request");
    AST_REL_READ: assert property ($rose(REQ_N) && !IO_N && !ACK_N |-> ##[1:11] ACK_N)
        else $error("read ack held too long");
    AST_REL_WRITE: assert property ($rose(REQ_N) && IO_N && !ACK_N |=> !ACK_N [*8])
        else $error("write ack released early");
    AST_IRQ_QUAL: assert property (IRQ1 |-> gap_ff < 4'h6)
        else $error("interrupt without data or status request");
    AST_IACK_DISARM: assert property (IRQ1 && IACK && !CPU_REQ |-> ##[1:2] !IRQ1)
        else $error("interrupt kept after vector fetch");
    AST_ARM_DONE: assert property (arm |=> CPU_DONE)
        else $error("arming write not completed");
    AST_ARM_PENDING: assert property (qual [*4] ##0 arm |-> ##[1:4] IRQ1)
        else $error("pending request not interrupting");
    AST_SEL_END: assert property (!SEL_N && !BSY_N |-> ##[1:4] SEL_N)
        else $error("select not released after busy");
    AST_DB_DRIVE: assert property (!ACK_N |-> DB_OE_N == !IO_N)
        else $error("data bus drive wrong for transfer direction");
    COV_IRQ: cover property ($rose(IRQ1));
    COV_SEL: cover property ($rose(SEL_N));
    COV_BYTE: cover property ($rose(ACK_N));
endmodule // sas_host_port_chk
bind sas_host_port sas_host_port_chk sas_host_port_chk_i (.CLK(CLK), .RST_N(RST_N),
    .CPU_REQ(CPU_REQ), .CPU_WR(CPU_WR), .CPU_ADDR(CPU_ADDR), .CPU_DONE(CPU_DONE),
    .IRQ1(IRQ1), .IACK(IACK), .REQ_N(REQ_N), .IO_N(IO_N), .CD_N(CD_N), .BSY_N(BSY_N),
    .ACK_N(ACK_N), .SEL_N(SEL_N), .RST_OUT_N(RST_OUT_N), .DB_OE_N(DB_OE_N));

// file: bench/sas_ctrl_model.sv
// behavioural disk controller at the far end of the cable
`timescale 1ns/1ps
module sas_ctrl_model (
    // host-driven lines
    input wire CLK, input wire ACK_N, input wire SEL_N, input wire [7:0] DB_OUT,
    // controller-driven lines
    output reg REQ_N, output reg IO_N, output reg CD_N, output reg MSG_N,
    output reg BSY_N, output reg [7:0] DB_IN
);
    reg [7:0] got_q[$];
    initial begin
        {REQ_N, IO_N, CD_N, MSG_N, BSY_N} = 5'h1f;
        DB_IN = 8'h5a;
    end
    always @(posedge CLK) begin
        if (!SEL_N && DB_OUT == 8'h01 && BSY_N) #1 BSY_N = 1'b0;
    end
    task phase(input [2:0] icm);
        {IO_N, CD_N, MSG_N} = icm;
    endtask
    task byte_xfer(input [7:0] d, input integer lag);
        begin
            repeat (lag) @(posedge CLK);
            // start each request one step after an edge, like all other stimulus
            @(posedge CLK);
            #1 DB_IN = d;
            REQ_N = 1'b0;
            @(posedge CLK);
            while (ACK_N) @(posedge CLK);
            if (IO_N) got_q.push_back(DB_OUT);
            repeat (lag) @(posedge CLK);
            #1 REQ_N = 1'b1;
            @(posedge CLK);
            while (!ACK_N) @(posedge CLK);
            // released data shows the inverse so stale bytes never match
            #1 DB_IN = ~d;
        end
    endtask
endmodule // sas_ctrl_model

// file: bench/test_sas_host_port.sv
// self-checking bench for the cable-side host adapter
`timescale 1ns/1ps
module test_sas_host_port;
    reg CLK, RST_N, CPU_REQ, CPU_WR, IACK, berr;
    reg [3:0] CPU_ADDR;
    reg [1:0] CPU_SIZE;
    reg [31:0] CPU_WDATA, d, exp, g;
    wire [31:0] CPU_RDATA;
    wire CPU_DONE, CPU_BERR, IRQ1, REQ_N, IO_N, CD_N, MSG_N, BSY_N, ACK_N, SEL_N, RST_OUT_N;
    wire DB_OE_N;
    wire [7:0] DB_IN, DB_OUT;
    integer bad_count, num_checks, i, j, k, n;
    sas_host_port #(.TMO_CYC(50)) sas_host_port_i (.CLK(CLK), .RST_N(RST_N),
        .CPU_REQ(CPU_REQ), .CPU_WR(CPU_WR), .CPU_ADDR(CPU_ADDR), .CPU_SIZE(CPU_SIZE),
        .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA), .CPU_DONE(CPU_DONE),
        .CPU_BERR(CPU_BERR), .IRQ1(IRQ1), .IACK(IACK), .REQ_N(REQ_N), .IO_N(IO_N),
        .CD_N(CD_N), .MSG_N(MSG_N), .BSY_N(BSY_N), .DB_IN(DB_IN), .ACK_N(ACK_N),
        .SEL_N(SEL_N), .RST_OUT_N(RST_OUT_N), .DB_OUT(DB_OUT), .DB_OE_N(DB_OE_N));
    sas_ctrl_model sas_ctrl_model_i (.CLK(CLK), .ACK_N(ACK_N), .SEL_N(SEL_N),
        .DB_OUT(DB_OUT), .REQ_N(REQ_N), .IO_N(IO_N), .CD_N(CD_N), .MSG_N(MSG_N),
        .BSY_N(BSY_N), .DB_IN(DB_IN));
    task chk(input [31:0] seen, input [31:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("ERROR %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    task wt(input integer c);
        begin
            repeat (c) @(posedge CLK);
            #1;
        end
    endtask
    // one processor access, held until done or bus error
    task cpu(input wr, input [3:0] a, input [1:0] sz, input [31:0] wd);
        begin
            wt(1);
            {CPU_REQ, CPU_WR, CPU_ADDR, CPU_SIZE, CPU_WDATA} = {1'b1, wr, a, sz, wd};
            k = 0;
            do begin wt(1); k = k + 1; end while (!CPU_DONE && !CPU_BERR && k < 3000);
            berr = CPU_BERR;
            CPU_REQ = 1'b0;
        end
    endtask
    // expected status from the lines the controller shows
    function [31:0] stat_exp();
        stat_exp = {24'h0, !BSY_N, 3'h0, !REQ_N && !CD_N && IO_N, !REQ_N && CD_N && IO_N,
            !REQ_N && CD_N && !IO_N, !REQ_N && !CD_N && !IO_N};
    endfunction
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // watchdog at 50000 cycles, far beyond the expected several hundred cycles
    initial begin
        #200000 bad_count = bad_count + 1;
        summarize;
    end
    initial begin
        {RST_N, CPU_REQ, CPU_WR, IACK, CPU_ADDR, CPU_SIZE, CPU_WDATA} = 0;
        bad_count = 0;
        num_checks = 0;
        d = $urandom(37);
        wt(16);
        RST_N = 1'b1;
        cpu(0, 4'hc, 0, 0); chk(berr, 1);
        cpu(0, 4'h0, 0, 0); chk(berr, 1);
        cpu(1, 4'hd, 1, 1); chk(berr, 1);
        // busy tested first, interrupts left unarmed around selection
        cpu(0, 4'hd, 0, 0); chk(CPU_RDATA, stat_exp());
        cpu(1, 4'hd, 0, 2); chk(berr, 1);
        cpu(0, 4'hd, 0, 0); chk(CPU_RDATA, stat_exp());
        cpu(1, 4'hd, 0, 1); chk(berr, 0);
        cpu(0, 4'hd, 0, 0); chk(CPU_RDATA, stat_exp());
        $display("select test done");
        // bytes, words, long words in both directions, prompt and slow
        for (i = 0; i < 6; i = i + 1) begin
            n = 1 << (i % 3);
            d = $urandom;
            exp = 0;
            g = 0;
            sas_ctrl_model_i.phase({i < 3, 2'b11});
            fork
                cpu(i < 3, 4'h8, i % 3, d);
                for (j = 0; j < n; j = j + 1) begin
                    exp = {exp[23:0], d[8 * (n - 1 - j) +: 8]};
                    sas_ctrl_model_i.byte_xfer(d[8 * (n - 1 - j) +: 8], $urandom % 4);
                end
            join
            chk(berr, 0);
            chk(DB_OE_N, 1);
            while (sas_ctrl_model_i.got_q.size() > 0)
                g = {g[23:0], sas_ctrl_model_i.got_q.pop_front()};
            chk(i < 3 ? g : CPU_RDATA, exp);
        end
        $display("transfer test done");
        sas_ctrl_model_i.phase(3'b011);
        sas_ctrl_model_i.REQ_N = 1'b0;
        cpu(1, 4'h8, 0, 0); chk(berr, 1);
        // every phase decodes to its own status bit
        for (i = 0; i < 4; i = i + 1) begin
            sas_ctrl_model_i.phase(12'b101_111_011_001 >> (9 - 3 * i));
            wt(4);
            cpu(0, 4'hd, 0, 0); chk(CPU_RDATA, stat_exp());
        end
        $display("status test done");
        sas_ctrl_model_i.phase(3'b101);
        cpu(1, 4'hc, 0, $urandom); chk(berr, 0);
        wt(8); chk(IRQ1, 0);
        sas_ctrl_model_i.phase(3'b111);
        wt(6); chk(IRQ1, 1);
        IACK = 1'b1; wt(1); IACK = 1'b0; wt(3); chk(IRQ1, 0);
        sas_ctrl_model_i.REQ_N = 1'b1; wt(4); sas_ctrl_model_i.REQ_N = 1'b0;
        wt(6); chk(IRQ1, 0);
        cpu(1, 4'hc, 0, 0); wt(4); chk(IRQ1, 1);
        sas_ctrl_model_i.REQ_N = 1'b1; wt(6); chk(IRQ1, 0);
        sas_ctrl_model_i.phase(3'b001); sas_ctrl_model_i.REQ_N = 1'b0;
        wt(6); chk(IRQ1, 1);
        IACK = 1'b1; wt(1); IACK = 1'b0; sas_ctrl_model_i.REQ_N = 1'b1;
        wt(3); chk(IRQ1, 0);
        $display("interrupt test done");
        summarize;
    end
endmodule // test_sas_host_port
